/* hdl/sync_cfg.svh */
// constants for the sysref capture block and its controller
`ifndef SYNC_CFG_SVH
`define SYNC_CFG_SVH
// ***********************
// device register offsets
// ***********************
`define ADDR_CLK_DIV   12'h10B
`define ADDR_CTL       12'h120
`define ADDR_IGNORE    12'h121
`define ADDR_SKEW      12'h122
`define ADDR_TS_DELAY  12'h123
`define ADDR_MONITOR   12'h128
`define ADDR_SYNC_MODE 12'h1FF
`define ADDR_FUNC01    12'h559
`define ADDR_FUNC2     12'h55A
`define ADDR_CB_COUNT  12'h58F
`define RST_REG        8'h00
// ***********************
// device fields and codes
// ***********************
`define CTL_TRANS      4
`define CTL_EDGE       3
`define CTL_MODE       2:1
`define DIV_RATIO      3:0
`define IGN_FIELD      3:0
`define SKEW_NEG       3:2
`define SKEW_POS       1:0
`define SYNC_TS        0
`define CB_FIELD       7:6
`define MON_HOLD       7:4
`define MON_SETUP      3:0
`define MODE_OFF       2'h0
`define MODE_CONT      2'h1
`define MODE_NSHOT     2'h2
`define FUNC_SYSREF    4'h5
`define HOLD_GOOD      4'h8
`define RUN_MAX        4'hF
`define CB_NUM         3
`define RS_DIV         0
`define RS_DDC         1
`define RS_MON         2
`define RS_LINK        3
// ***********************
// controller registers
// ***********************
`define H_CMD          4'h0
`define H_STAT         4'h4
`define H_GEN          4'h8
`define H_TSCNT        4'hC
`define CMD_ADDR       11:0
`define CMD_DATA       23:16
`define CMD_WR         24
`define CMD_RD         25
`define STAT_BUSY      8
`define GEN_WIDTH      7:0
`define GEN_MULT       15:8
`define GEN_CONT       16
`define GEN_ONE        17
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
`endif

/* hdl/sync_pkg.sv */
// types shared by the sysref device and its controller
package sync_pkg;
    typedef logic [3:0] resync_type;
    typedef enum logic [1:0] {
        OP_IDLE = 2'b01,
        OP_WAIT = 2'b10
    } op_state_type;
endpackage : sync_pkg

/* hdl/sync_if.sv */
// link between the sysref device and the controller that configures it
`timescale 1ns/10ps
interface sync_if;
    logic [11:0] reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_we;
    logic        reg_re;
    logic [7:0]  reg_rdata;
    logic        reg_ack;
    logic        sysref;
    logic [2:0]  ctrl_bits;
    logic        lmfc_edge;
    modport device (input reg_addr, reg_wdata, reg_we, reg_re, sysref,
                    output reg_rdata, reg_ack, ctrl_bits, lmfc_edge);
    modport host (output reg_addr, reg_wdata, reg_we, reg_re, sysref,
                  input reg_rdata, reg_ack, ctrl_bits, lmfc_edge);
endinterface : sync_if

/* hdl/phase_counter.sv */
// wrapping phase counter with restart, used for the internal dividers
`timescale 1ns/10ps
module phase_counter #(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // control
    input  wire logic         restart,
    input  wire logic [W-1:0] len,
    // state
    output logic      [W-1:0] phase
);
    wire logic last = (phase >= len - W'(1));

    always_ff @(posedge aclk) begin
        if (!aresetn || restart) begin
            phase <= '0;
        end else if (last) begin
            phase <= '0;
        end else begin
            phase <= phase + W'(1);
        end
    end
endmodule : phase_counter

/* hdl/sysref_device.sv */
// sysref capture, skew window, monitor and timestamp marking
`include "sync_cfg.svh"
`timescale 1ns/10ps

// How it works
// R1: sync mode bit picks normal or timestamp
// R2: sync mode bit resets to normal
// R3: timestamp mode marks sample, keeps clocks running
// R4: host sets continuous or n-shot first
// R5: host enables at least one control bit
// R6: function code 5 routes timestamp to bit
// R7: timestamp delay shifts the marked sample
// R8: no timestamp while decimation is active
// R9: nonzero mode selects type and arms
// R10: n-shot mode clears itself after capture
// R11: sysref pulse at least two divided clocks (host clamps to MIN_WIDTH aclk cycles, whatever the device divider)
// R12: continuous period is whole lmfc multiple
// R13: normal capture resyncs divider, ddc, monitor, link
// R14: transition bit picks rising or falling event
// R15: edge bit picks sampling edge
// R16: n-shot skips up to 15 events first
// R17: continuous mode resyncs when off lmfc
// R18: capture inside skew window disturbs nothing (continuous mode only; n-shot captures resync inside the window too)
// R19: negative skew before phase zero, positive after
// R20: monitor shows hold, setup and capture
// R21: setup before edge, hold after edge
// R22: monitor codes grade setup and hold margin
// R23: continuous mode stays armed after captures
module sysref_device #(
    parameter int LMFC_LEN = 32
) (
    // clock and reset
    input  wire logic          aclk,
    input  wire logic          aresetn,
    // link to the controller
    sync_if.device             lnk,
    // user side
    input  wire logic          decimate,
    output sync_pkg::resync_type resync,
    output logic               captured
);
    import sync_pkg::*;

    // ***********************
    // register file
    // ***********************
    logic [7:0] clk_div_q, ctl_q, ign_cnt_q, skew_q, ts_delay_q;
    logic [7:0] mon_q, sync_mode_q, func01_q, func2_q, cb_count_q;
    logic [7:0] rdata_d;
    logic       act;
    logic [1:0] mode;
    wire logic  wr     = lnk.reg_we;
    wire logic  ctl_wr = wr && (lnk.reg_addr == `ADDR_CTL);

    assign mode = ctl_q[`CTL_MODE];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clk_div_q   <= `RST_REG;
            ign_cnt_q   <= `RST_REG;
            skew_q      <= `RST_REG;
            ts_delay_q  <= `RST_REG;
            sync_mode_q <= `RST_REG; // [R2]
            func01_q    <= `RST_REG;
            func2_q     <= `RST_REG;
            cb_count_q  <= `RST_REG;
        end else if (wr) begin
            unique case (lnk.reg_addr)
                `ADDR_CLK_DIV:   clk_div_q   <= lnk.reg_wdata;
                `ADDR_IGNORE:    ign_cnt_q   <= lnk.reg_wdata;
                `ADDR_SKEW:      skew_q      <= lnk.reg_wdata;
                `ADDR_TS_DELAY:  ts_delay_q  <= lnk.reg_wdata;
                `ADDR_SYNC_MODE: sync_mode_q <= lnk.reg_wdata;
                `ADDR_FUNC01:    func01_q    <= lnk.reg_wdata;
                `ADDR_FUNC2:     func2_q     <= lnk.reg_wdata;
                `ADDR_CB_COUNT:  cb_count_q  <= lnk.reg_wdata;
                default: ;
            endcase
        end
    end

    // a software write wins over the self clear, so a re-arm is never lost
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl_q <= `RST_REG;
        end else if (ctl_wr) begin
            ctl_q <= lnk.reg_wdata; // [R9]
        end else if (act && mode == `MODE_NSHOT) begin
            ctl_q[`CTL_MODE] <= `MODE_OFF; // [R10]
        end
    end

    always_comb begin
        unique case (lnk.reg_addr)
            `ADDR_CLK_DIV:   rdata_d = clk_div_q;
            `ADDR_CTL:       rdata_d = ctl_q;
            `ADDR_IGNORE:    rdata_d = ign_cnt_q;
            `ADDR_SKEW:      rdata_d = skew_q;
            `ADDR_TS_DELAY:  rdata_d = ts_delay_q;
            `ADDR_MONITOR:   rdata_d = mon_q; // [R20]
            `ADDR_SYNC_MODE: rdata_d = sync_mode_q;
            `ADDR_FUNC01:    rdata_d = func01_q;
            `ADDR_FUNC2:     rdata_d = func2_q;
            `ADDR_CB_COUNT:  rdata_d = cb_count_q;
            default:         rdata_d = `RST_REG;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lnk.reg_rdata <= `RST_REG;
            lnk.reg_ack   <= 1'b0;
        end else begin
            lnk.reg_ack <= lnk.reg_we | lnk.reg_re;
            if (lnk.reg_re) begin
                lnk.reg_rdata <= rdata_d;
            end
        end
    end

    // ***********************
    // sysref sampling and event qualification
    // ***********************
    // one clock only: the falling-edge option is modelled as a sample taken
    // one cycle later, which keeps the event half a period late of true hw
    logic s0_q, s1_q, prev_q, evt;
    logic [3:0] ign_q;
    wire logic smp = ctl_q[`CTL_EDGE] ? s1_q : s0_q; // [R15]

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s0_q   <= 1'b0;
            s1_q   <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            s0_q   <= lnk.sysref;
            s1_q   <= s0_q;
            prev_q <= smp;
        end
    end

    always_comb begin
        evt = ctl_q[`CTL_TRANS] ? (prev_q & ~smp) : (~prev_q & smp); // [R14]
        evt = evt && (mode != `MODE_OFF); // [R9]
        act = evt && (mode == `MODE_CONT || (mode == `MODE_NSHOT && ign_q == '0)); // [R23]
    end

    // ignore count is loaded whenever the mode field is written
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ign_q <= '0;
        end else if (ctl_wr) begin
            ign_q <= ign_cnt_q[`IGN_FIELD];
        end else if (evt && mode == `MODE_NSHOT && ign_q != '0) begin
            ign_q <= ign_q - 4'h1; // [R16]
        end
    end

    // ***********************
    // internal dividers and realignment
    // ***********************
    logic [3:0] div_phase;
    logic [7:0] lmfc_phase, cap_ph;
    logic       in_win, do_sync;
    wire logic  ts_mode = sync_mode_q[`SYNC_TS]; // [R1]

    phase_counter #(.W(4)) div_cnt (
        .aclk    (aclk),
        .aresetn (aresetn),
        .restart (do_sync),
        .len     (clk_div_q[`DIV_RATIO] + 4'h1),
        .phase   (div_phase)
    );

    phase_counter #(.W(8)) lmfc_cnt (
        .aclk    (aclk),
        .aresetn (aresetn),
        .restart (do_sync),
        .len     (8'(LMFC_LEN)),
        .phase   (lmfc_phase)
    );

    always_comb begin
        // a restart zeroes the phase one cycle after the capture: judge the next phase
        cap_ph = (lmfc_phase == 8'(LMFC_LEN) - 8'h1) ? '0 : lmfc_phase + 8'h1;
        in_win = (cap_ph <= 8'(skew_q[`SKEW_POS])) ||
                 (cap_ph >= 8'(LMFC_LEN) - 8'(skew_q[`SKEW_NEG])); // [R19]
        do_sync = act && !ts_mode &&
                  (mode != `MODE_CONT || !in_win); // [R13] [R17] [R18]
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            resync        <= '0;
            lnk.lmfc_edge <= 1'b0;
        end else begin
            resync[`RS_DIV]  <= do_sync; // [R13]
            resync[`RS_DDC]  <= do_sync;
            resync[`RS_MON]  <= do_sync;
            resync[`RS_LINK] <= do_sync;
            lnk.lmfc_edge    <= (lmfc_phase == '0);
        end
    end

    // ***********************
    // timestamp marking
    // ***********************
    logic       pend_q, mark;
    logic [7:0] dly_q;
    logic [3:0] func [`CB_NUM];

    assign mark = pend_q && (dly_q == '0);
    assign func[0] = func01_q[3:0];
    assign func[1] = func01_q[7:4];
    assign func[2] = func2_q[3:0]; // [R6]

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pend_q <= 1'b0;
            dly_q  <= '0;
        end else if (act && ts_mode && !decimate) begin
            pend_q <= 1'b1; // [R3] [R8]
            dly_q  <= ts_delay_q; // [R7]
        end else if (mark) begin
            pend_q <= 1'b0;
        end else if (pend_q) begin
            dly_q <= dly_q - 8'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lnk.ctrl_bits <= '0;
        end else begin
            for (int i = 0; i < `CB_NUM; i++) begin
                lnk.ctrl_bits[i] <= mark && (2'(i) < cb_count_q[`CB_FIELD]) &&
                                    (func[i] == `FUNC_SYSREF); // [R5] [R6]
            end
        end
    end

    // ***********************
    // setup/hold monitor
    // ***********************
    // setup: how long the old level stood before the event, saturating;
    // hold: how long the new level stood after it, up to the good code
    logic [3:0] run_q;
    logic       hold_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_q <= '0;
        end else if (smp != prev_q) begin
            run_q <= '0;
        end else if (run_q != `RUN_MAX) begin
            run_q <= run_q + 4'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mon_q  <= `RST_REG;
            hold_q <= 1'b0;
        end else if (act) begin
            mon_q[`MON_SETUP] <= run_q; // [R21] [R22]
            mon_q[`MON_HOLD]  <= '0;
            hold_q            <= 1'b1;
        end else if (hold_q) begin
            if (smp == prev_q && mon_q[`MON_HOLD] != `HOLD_GOOD) begin
                mon_q[`MON_HOLD] <= mon_q[`MON_HOLD] + 4'h1; // [R21]
            end else begin
                hold_q <= 1'b0;
            end
        end
    end

    // captured stands until the mode field is written again
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            captured <= 1'b0;
        end else if (act) begin
            captured <= 1'b1; // [R20]
        end else if (ctl_wr) begin
            captured <= 1'b0;
        end
    end
endmodule : sysref_device

/* hdl/sysref_host.sv */
// controller: axi4-lite slave, device register access, sysref source
`include "sync_cfg.svh"
`timescale 1ns/10ps
module sysref_host #(
    parameter int LMFC_LEN  = 32,
    parameter int MIN_WIDTH = 2
) (
    // clock and reset
    input  wire logic          aclk,
    input  wire logic          aresetn,
    // axi4-lite slave
    input  wire logic [3:0]    awaddr,
    input  wire logic          awvalid,
    output logic               awready,
    input  wire logic [31:0]   wdata,
    input  wire logic [3:0]    wstrb,
    input  wire logic          wvalid,
    output logic               wready,
    output logic [1:0]         bresp,
    output logic               bvalid,
    input  wire logic          bready,
    input  wire logic [3:0]    araddr,
    input  wire logic          arvalid,
    output logic               arready,
    output logic [31:0]        rdata,
    output logic [1:0]         rresp,
    output logic               rvalid,
    input  wire logic          rready,
    // link to the device
    sync_if.host               lnk,
    // status
    output sync_pkg::op_state_type op_state
);
    import sync_pkg::*;

    // ***********************
    // write channel
    // ***********************
    logic [3:0]  aw_q;
    logic [31:0] w_q;
    logic        aw_have, w_have, do_wr;
    logic [17:0] gen_q;
    logic [15:0] ts_cnt_q;
    logic [7:0]  dev_rd_q;
    wire logic   aw_take = awvalid && awready;
    wire logic   w_take  = wvalid && wready;

    assign do_wr = aw_have && w_have && !bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have <= 1'b0;
            w_have  <= 1'b0;
            awready <= 1'b0;
            wready  <= 1'b0;
            aw_q    <= '0;
            w_q     <= '0;
        end else begin
            if (aw_take) begin
                aw_have <= 1'b1;
                aw_q    <= awaddr;
            end else if (do_wr) begin
                aw_have <= 1'b0;
            end
            if (w_take) begin
                w_have <= 1'b1;
                w_q    <= wdata;
            end else if (do_wr) begin
                w_have <= 1'b0;
            end
            awready <= !(aw_have || aw_take) && !bvalid && !do_wr;
            wready  <= !(w_have || w_take) && !bvalid && !do_wr;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= `RESP_OKAY;
        end else if (do_wr) begin
            bvalid <= 1'b1;
            bresp  <= (aw_q == `H_CMD || aw_q == `H_GEN) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // ***********************
    // read channel
    // ***********************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= '0;
            rresp   <= `RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rresp   <= `RESP_OKAY;
            unique case (araddr)
                `H_STAT:  rdata <= {23'h0, op_state == OP_WAIT, dev_rd_q};
                `H_GEN:   rdata <= {14'h0, gen_q};
                `H_TSCNT: rdata <= {16'h0, ts_cnt_q};
                default: begin
                    rdata <= '0;
                    rresp <= `RESP_SLVERR;
                end
            endcase
        end else if (rvalid) begin
            rvalid  <= !rready;
            arready <= rready;
        end else begin
            arready <= 1'b1;
        end
    end

    // ***********************
    // device register access
    // ***********************
    // a command written while busy is dropped; software polls the busy bit
    wire logic cmd_go = do_wr && aw_q == `H_CMD && op_state == OP_IDLE &&
                        (w_q[`CMD_WR] || w_q[`CMD_RD]);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            op_state      <= OP_IDLE;
            lnk.reg_addr  <= '0;
            lnk.reg_wdata <= '0;
            lnk.reg_we    <= 1'b0;
            lnk.reg_re    <= 1'b0;
            dev_rd_q      <= '0;
        end else begin
            lnk.reg_we <= cmd_go && w_q[`CMD_WR]; // [R4] [R5]
            lnk.reg_re <= cmd_go && !w_q[`CMD_WR];
            unique case (op_state)
                OP_IDLE: if (cmd_go) begin
                    lnk.reg_addr  <= w_q[`CMD_ADDR];
                    lnk.reg_wdata <= w_q[`CMD_DATA];
                    op_state      <= OP_WAIT;
                end
                OP_WAIT: if (lnk.reg_ack) begin
                    dev_rd_q <= lnk.reg_rdata;
                    op_state <= OP_IDLE;
                end
            endcase
        end
    end

    // ***********************
    // sysref source
    // ***********************
    logic [15:0] per_cnt_q;
    logic [7:0]  width;
    logic [15:0] period;

    always_comb begin
        width  = (gen_q[`GEN_WIDTH] < 8'(MIN_WIDTH)) ? 8'(MIN_WIDTH)
                                                     : gen_q[`GEN_WIDTH]; // [R11]
        period = (gen_q[`GEN_MULT] == '0 ? 16'h1 : 16'(gen_q[`GEN_MULT]))
                 * 16'(LMFC_LEN); // [R12]
    end

    // a single-shot request wins over its own clear at the end of the pulse
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gen_q <= '0;
        end else if (do_wr && aw_q == `H_GEN) begin
            gen_q <= w_q[17:0];
        end else if (gen_q[`GEN_ONE] && per_cnt_q == 16'(width)) begin
            gen_q[`GEN_ONE] <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            per_cnt_q  <= '0;
            lnk.sysref <= 1'b0;
        end else if (gen_q[`GEN_CONT] || gen_q[`GEN_ONE]) begin
            per_cnt_q  <= (per_cnt_q >= period - 16'h1) ? '0 : per_cnt_q + 16'h1;
            lnk.sysref <= per_cnt_q < 16'(width);
        end else begin
            per_cnt_q  <= '0;
            lnk.sysref <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ts_cnt_q <= '0;
        end else if (lnk.ctrl_bits != '0) begin
            ts_cnt_q <= ts_cnt_q + 16'h1; // [R6]
        end
    end
endmodule : sysref_host

/* tb/sync_link_properties.sv */
// assertions on the link between the sysref device and its controller
`include "sync_cfg.svh"
`timescale 1ns/10ps
module sync_link_checker (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // register access
    input wire logic [11:0] reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_we,
    input wire logic        reg_re,
    input wire logic [7:0]  reg_rdata,
    input wire logic        reg_ack,
    // sysref and marking
    input wire logic        sysref,
    input wire logic [2:0]  ctrl_bits,
    input wire logic        lmfc_edge
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    logic [7:0] fn01_q;
    logic [7:0] fn2_q;
    logic [7:0] cnt_q;
    logic [7:0] ctl_q;
    logic       sync_q;
    logic [2:0] cnt_mask;
    logic [2:0] fn_mask;
    // ************
    // shadow state
    // ************
    // the n-shot self clear is not mirrored, so mode checks use continuous only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fn01_q <= `RST_REG;
            fn2_q  <= `RST_REG;
            cnt_q  <= `RST_REG;
            ctl_q  <= `RST_REG;
            sync_q <= 1'b0;
        end else if (reg_we) begin
            case (reg_addr)
                `ADDR_FUNC01:    fn01_q <= reg_wdata;
                `ADDR_FUNC2:     fn2_q <= reg_wdata;
                `ADDR_CB_COUNT:  cnt_q <= reg_wdata;
                `ADDR_CTL:       ctl_q <= reg_wdata;
                `ADDR_SYNC_MODE: sync_q <= reg_wdata[`SYNC_TS];
                default: ;
            endcase
        end
    end
    assign cnt_mask = {cnt_q[7:6] == 2'h3, cnt_q[7:6] >= 2'h2, cnt_q[7:6] != 2'h0};
    assign fn_mask  = {fn2_q[3:0] == `FUNC_SYSREF, fn01_q[7:4] == `FUNC_SYSREF,
                       fn01_q[3:0] == `FUNC_SYSREF};
    // **********
    // assertions
    // **********
    a_ctrl_count_limit: assert property (ctrl_bits != 3'h0 |-> (ctrl_bits & ~cnt_mask) == 3'h0)
        else $error("control bit beyond enabled count");
    a_ctrl_func_sel: assert property (ctrl_bits != 3'h0 |-> (ctrl_bits & ~fn_mask) == 3'h0)
        else $error("control bit marked without sysref function");
    a_ctrl_ts_only: assert property (ctrl_bits != 3'h0 |-> sync_q)
        else $error("timestamp marked in normal mode");
    a_sync_readback: assert property (reg_re && reg_addr == `ADDR_SYNC_MODE
        |=> reg_ack && reg_rdata[`SYNC_TS] == sync_q)
        else $error("sync mode bit reads wrong");
    a_cont_stays_armed: assert property (reg_re && reg_addr == `ADDR_CTL
        && ctl_q[`CTL_MODE] == `MODE_CONT |=> reg_rdata[`CTL_MODE] == `MODE_CONT)
        else $error("continuous mode disarmed");
    a_edge_bits_kept: assert property (reg_re && reg_addr == `ADDR_CTL
        |=> reg_rdata[4:3] == ctl_q[4:3])
        else $error("transition or edge select reads wrong");
    a_func_readback: assert property (reg_re && reg_addr == `ADDR_FUNC01
        |=> reg_ack && reg_rdata == fn01_q)
        else $error("function selector reads wrong");
    a_sysref_min_width: assert property ($rose(sysref) |=> sysref)
        else $error("sysref pulse shorter than two cycles");
    c_marked: cover property (ctrl_bits != 3'h0);
    c_sysref: cover property ($rose(sysref));
    c_lmfc: cover property (lmfc_edge);
endmodule : sync_link_checker

/* tb/sysref_capture_multichip_sync_tb.sv */
// self-checking bench for the sysref device and its controller
`include "sync_cfg.svh"
`timescale 1ns/10ps
module sysref_capture_multichip_sync_tb;
    import sync_pkg::*;
    localparam int LMFC = 16;
    logic         aclk = 1'b0;
    logic         aresetn = 1'b0;
    logic         decimate = 1'b0;
    logic [3:0]   awaddr = 4'h0;
    logic [3:0]   araddr = 4'h0;
    logic [3:0]   wstrb = 4'hF;
    logic [31:0]  wdata = 32'h0;
    logic         awvalid = 1'b0;
    logic         wvalid = 1'b0;
    logic         arvalid = 1'b0;
    logic         bready = 1'b1;
    logic         rready = 1'b1;
    logic         awready, wready, bvalid, arready, rvalid, captured;
    logic [1:0]   bresp, rresp, r;
    logic [31:0]  rdata, s, t0;
    resync_type   resync;
    op_state_type op_state;
    logic         sr_q = 1'b0;
    int errors = 0, n_compared = 0, n_rise = 0, n_resync = 0, n_full = 0, first_at = 0;
    sync_if lnk ();
    sysref_host #(.LMFC_LEN(LMFC), .MIN_WIDTH(2)) i_sysref_host (.aclk, .aresetn, .awaddr,
        .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
        .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .lnk, .op_state);
    sysref_device #(.LMFC_LEN(LMFC)) i_sysref_device (.aclk, .aresetn, .lnk, .decimate,
        .resync, .captured);
    sync_link_checker i_sync_link_checker (.aclk, .aresetn, .reg_addr(lnk.reg_addr),
        .reg_wdata(lnk.reg_wdata), .reg_we(lnk.reg_we), .reg_re(lnk.reg_re),
        .reg_rdata(lnk.reg_rdata), .reg_ack(lnk.reg_ack), .sysref(lnk.sysref),
        .ctrl_bits(lnk.ctrl_bits), .lmfc_edge(lnk.lmfc_edge));
    always #50 aclk = ~aclk;
    // *****************
    // monitor and tasks
    // *****************
    always @(posedge aclk) begin
        sr_q <= lnk.sysref;
        if (lnk.sysref && !sr_q) n_rise++;
        if (resync != 4'h0) begin
            n_resync++;
            if (resync === 4'hF) n_full++;
            if (first_at == 0) first_at = n_rise;
        end
    end
    task chk(input string what, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task axi_wr(input logic [3:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
    endtask : axi_wr
    task axi_rd(input logic [3:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        s = rdata;
        r = rresp;
    endtask : axi_rd
    // busy is polled since the device answer time is not fixed for software
    task dev_cmd(input logic [11:0] a, input logic [7:0] d, input logic rd);
        axi_wr(`H_CMD, {6'h00, rd, !rd, d, 4'h0, a});
        do axi_rd(`H_STAT); while (s[`STAT_BUSY] !== 1'b0);
    endtask : dev_cmd
    // stop lands in the low part of the pulse so no pulse is cut short
    task burst;
        axi_wr(`H_GEN, {15'h0000, 1'b1, 8'h02, 8'h0C});
        repeat (LMFC * 7) @(posedge aclk);
        axi_wr(`H_GEN, 32'h0);
    endtask : burst
    task close_out;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : close_out
    // *****
    // tests
    // *****
    initial begin
        repeat (20000) @(posedge aclk);
        errors++;
        close_out;
    end
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk("op_state", op_state, OP_IDLE);
        dev_cmd(`ADDR_SYNC_MODE, 8'h00, 1'b1);
        chk("sync mode", s[7:0], 8'h00);
        dev_cmd(`ADDR_CTL, 8'h00, 1'b1);
        chk("sysref control", s[7:0], 8'h00);
        axi_wr(`H_STAT, 32'h0);
        chk("bresp", r, `RESP_SLVERR);
        axi_rd(`H_CMD);
        chk("rresp", r, `RESP_SLVERR);
        chk("rdata", s, 32'h0);
        $display("test reset done");
        dev_cmd(`ADDR_IGNORE, 8'h01, 1'b0);
        dev_cmd(`ADDR_CTL, 8'h04, 1'b0);
        burst;
        chk("resyncs", n_resync, 1);
        chk("resync targets", n_full, 1);
        chk("acting event", first_at, 2);
        chk("captured", captured, 1'b1);
        dev_cmd(`ADDR_CTL, 8'h00, 1'b1);
        chk("mode cleared", s[7:0], 8'h00);
        dev_cmd(`ADDR_MONITOR, 8'h00, 1'b1);
        chk("monitor", s[7:0], 8'h8F);
        $display("test nshot done");
        dev_cmd(`ADDR_CTL, 8'h1A, 1'b0);
        n_resync = 0;
        burst;
        chk("captured", captured, 1'b1);
        chk("cont resyncs", n_resync <= 1, 1'b1);
        dev_cmd(`ADDR_CTL, 8'h00, 1'b1);
        chk("mode kept", s[7:0], 8'h1A);
        $display("test continuous done");
        dev_cmd(`ADDR_CB_COUNT, 8'h40, 1'b0);
        dev_cmd(`ADDR_FUNC01, 8'h05, 1'b0);
        dev_cmd(`ADDR_SYNC_MODE, 8'h01, 1'b0);
        dev_cmd(`ADDR_FUNC01, 8'h00, 1'b1);
        chk("function", s[7:0], 8'h05);
        dev_cmd(`ADDR_CB_COUNT, 8'h00, 1'b1);
        chk("bit count", s[7:0], 8'h40);
        n_resync = 0;
        burst;
        axi_rd(`H_TSCNT);
        t0 = s;
        chk("marked", t0 != 32'h0, 1'b1);
        chk("no resync", n_resync, 0);
        decimate <= 1'b1;
        burst;
        axi_rd(`H_TSCNT);
        chk("decimated", s, t0);
        $display("test timestamp done");
        close_out;
    end
endmodule : sysref_capture_multichip_sync_tb
